/* hw/sirq_map.svh */
// register offsets, reset values and field layout of the serial irq trigger/status block
`ifndef SIRQ_MAP_SVH
`define SIRQ_MAP_SVH
`define SIRQ_LINES            16
`define SIRQ_ADDR_W           8
`define SIRQ_MEM_TRIG_OFS     8'h4a
`define SIRQ_MEM_PEND_OFS     8'h4c
`define SIRQ_CFG_TRIG_OFS     8'he2
`define SIRQ_CFG_PEND_OFS     8'he4
`define SIRQ_TRIG_RESET       16'h0000
`define SIRQ_PEND_RESET       16'h0000
`define SIRQ_LO_BYTE          7:0
`define SIRQ_HI_BYTE          15:8
`endif

/* hw/sirq_pkg.sv */
// types shared by the serial irq trigger/status block
package sirq_pkg;
    typedef logic [15:0] line_vec_t;
    typedef logic [7:0]  reg_addr_t;
    typedef logic [1:0]  byte_en_t;
endpackage

/* hw/serial_irq_trigger_status.sv */
// per-line trigger select and level pending latch for the serial irq stream
`timescale 1ns/1ps
`include "sirq_map.svh"

module serial_irq_trigger_status
    import sirq_pkg::*;
#(
    parameter int LINES = `SIRQ_LINES
) (
    input  wire logic      I_MCLK,
    input  wire logic      I_RESET_N,
    input  wire line_vec_t i_LINE_ASSERT,
    input  wire logic      i_MEM_WR,
    input  wire logic      i_MEM_RD,
    input  wire reg_addr_t i_MEM_ADDR,
    input  wire byte_en_t  i_MEM_BE,
    input  wire line_vec_t i_MEM_WDATA,
    output line_vec_t      o_MEM_RDATA,
    input  wire logic      i_CFG_WR,
    input  wire logic      i_CFG_RD,
    input  wire reg_addr_t i_CFG_ADDR,
    input  wire byte_en_t  i_CFG_BE,
    input  wire line_vec_t i_CFG_WDATA,
    output line_vec_t      o_CFG_RDATA,
    output line_vec_t      o_LEVEL_SELECT,
    output line_vec_t      o_PENDING,
    output line_vec_t      o_EDGE_EVENT
);

    // the line vector type is fixed at sixteen bits, so no other count can be served
    if (LINES != `SIRQ_LINES) begin : g_bad_lines
        $error("LINES must be 16");
    end

    line_vec_t select_r;
    line_vec_t select_nxt;
    line_vec_t pending_r;
    line_vec_t pending_nxt;
    line_vec_t mem_rdata_r;
    line_vec_t cfg_rdata_r;
    line_vec_t edge_event_r;
    line_vec_t set_w;
    line_vec_t clr_w;
    line_vec_t mem_mask;
    line_vec_t cfg_mask;
    line_vec_t mem_rd_val;
    line_vec_t cfg_rd_val;
    logic      mem_trig_hit;
    logic      mem_pend_hit;
    logic      cfg_trig_hit;
    logic      cfg_pend_hit;

    // both windows decode onto the same two storage registers
    assign mem_trig_hit = (i_MEM_ADDR == `SIRQ_MEM_TRIG_OFS);
    assign mem_pend_hit = (i_MEM_ADDR == `SIRQ_MEM_PEND_OFS);
    assign cfg_trig_hit = (i_CFG_ADDR == `SIRQ_CFG_TRIG_OFS);
    assign cfg_pend_hit = (i_CFG_ADDR == `SIRQ_CFG_PEND_OFS);

    assign mem_mask = {{8{i_MEM_BE[1]}}, {8{i_MEM_BE[0]}}};
    assign cfg_mask = {{8{i_CFG_BE[1]}}, {8{i_CFG_BE[0]}}};

    // memory window wins a same-cycle select write; both paths are software anyway
    assign select_nxt =
        (i_MEM_WR && mem_trig_hit) ? ((select_r & ~mem_mask) | (i_MEM_WDATA & mem_mask)) :
        (i_CFG_WR && cfg_trig_hit) ? ((select_r & ~cfg_mask) | (i_CFG_WDATA & cfg_mask)) :
        select_r;

    assign clr_w = ((i_MEM_WR && mem_pend_hit) ? (i_MEM_WDATA & mem_mask) : '0)
                 | ((i_CFG_WR && cfg_pend_hit) ? (i_CFG_WDATA & cfg_mask) : '0);

    genvar g;
    generate
        for (g = 0; g < LINES; g++) begin : g_line
            // only a level-selected line records; edge lines go out through edge_event_r one cycle later
            assign set_w[g] = i_LINE_ASSERT[g] & select_r[g];
            // set beats clear so an assertion in the clearing cycle is kept
            assign pending_nxt[g] = set_w[g] | (pending_r[g] & ~clr_w[g]);
        end
    endgenerate

    assign mem_rd_val = mem_trig_hit ? select_r : (mem_pend_hit ? pending_r : '0);
    assign cfg_rd_val = cfg_trig_hit ? select_r : (cfg_pend_hit ? pending_r : '0);

    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            select_r     <= `SIRQ_TRIG_RESET;
            pending_r    <= `SIRQ_PEND_RESET;
            mem_rdata_r  <= '0;
            cfg_rdata_r  <= '0;
            edge_event_r <= '0;
        end else begin
            select_r     <= select_nxt;
            pending_r    <= pending_nxt;
            mem_rdata_r  <= i_MEM_RD ? mem_rd_val : mem_rdata_r;
            cfg_rdata_r  <= i_CFG_RD ? cfg_rd_val : cfg_rdata_r;
            edge_event_r <= i_LINE_ASSERT & ~select_r;
        end
    end

    assign o_MEM_RDATA    = mem_rdata_r;
    assign o_CFG_RDATA    = cfg_rdata_r;
    assign o_LEVEL_SELECT = select_r;
    assign o_PENDING      = pending_r;
    assign o_EDGE_EVENT   = edge_event_r;

    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RESET_N);

    sel_write_a: assert property (
        (i_MEM_WR && i_MEM_ADDR == `SIRQ_MEM_TRIG_OFS && i_MEM_BE == 2'h3)
        |=> o_LEVEL_SELECT == $past(i_MEM_WDATA))
        else $error("select write through memory window not stored");

    cfg_sel_write_a: assert property (
        (i_CFG_WR && i_CFG_ADDR == `SIRQ_CFG_TRIG_OFS && i_CFG_BE == 2'h3
         && !(i_MEM_WR && i_MEM_ADDR == `SIRQ_MEM_TRIG_OFS))
        |=> o_LEVEL_SELECT == $past(i_CFG_WDATA))
        else $error("select write through config alias not stored");

    mem_wins_a: assert property (
        (i_MEM_WR && i_MEM_ADDR == `SIRQ_MEM_TRIG_OFS && i_MEM_BE == 2'h3
         && i_CFG_WR && i_CFG_ADDR == `SIRQ_CFG_TRIG_OFS)
        |=> o_LEVEL_SELECT == $past(i_MEM_WDATA))
        else $error("config write beat a same-cycle memory write");

    select_hold_a: assert property (
        (!(i_MEM_WR && i_MEM_ADDR == `SIRQ_MEM_TRIG_OFS)
         && !(i_CFG_WR && i_CFG_ADDR == `SIRQ_CFG_TRIG_OFS))
        |=> $stable(o_LEVEL_SELECT))
        else $error("select changed without a write");

    // back-to-back write then read across the two windows must agree
    cfg_alias_a: assert property (
        (i_CFG_WR && i_CFG_ADDR == `SIRQ_CFG_TRIG_OFS && i_CFG_BE == 2'h3 && !i_MEM_WR)
        ##1 (i_MEM_RD && i_MEM_ADDR == `SIRQ_MEM_TRIG_OFS)
        |=> o_MEM_RDATA == $past(i_CFG_WDATA, 2))
        else $error("config select write not seen in memory window");

    pend_alias_a: assert property (
        (i_CFG_RD && i_CFG_ADDR == `SIRQ_CFG_PEND_OFS) |=> o_CFG_RDATA == $past(pending_r))
        else $error("config pending alias differs from storage");

    cfg_sel_read_a: assert property (
        (i_CFG_RD && i_CFG_ADDR == `SIRQ_CFG_TRIG_OFS) |=> o_CFG_RDATA == $past(select_r))
        else $error("config select alias differs from storage");

    mem_pend_read_a: assert property (
        (i_MEM_RD && i_MEM_ADDR == `SIRQ_MEM_PEND_OFS) |=> o_MEM_RDATA == $past(pending_r))
        else $error("memory pending read differs from storage");

    unmapped_read_a: assert property (
        (i_MEM_RD && i_MEM_ADDR != `SIRQ_MEM_TRIG_OFS && i_MEM_ADDR != `SIRQ_MEM_PEND_OFS)
        |=> o_MEM_RDATA == 16'h0000)
        else $error("unmapped memory read returned data");

    rdata_hold_a: assert property (
        !i_MEM_RD |=> $stable(o_MEM_RDATA))
        else $error("memory read data changed without a read");

    level_set_a: assert property (
        |(i_LINE_ASSERT & select_r)
        |=> (o_PENDING & $past(i_LINE_ASSERT) & $past(select_r))
            == ($past(i_LINE_ASSERT) & $past(select_r)))
        else $error("level line did not set its pending bit");

    edge_quiet_a: assert property (
        ##1 (o_PENDING & ~$past(pending_r) & ~$past(select_r)) == 16'h0000)
        else $error("edge line set a pending bit");

    edge_pass_a: assert property (
        ##1 o_EDGE_EVENT == ($past(i_LINE_ASSERT) & ~$past(o_LEVEL_SELECT)))
        else $error("edge event not forwarded per line");

    w1c_clear_a: assert property (
        (i_MEM_WR && i_MEM_ADDR == `SIRQ_MEM_PEND_OFS && i_MEM_BE == 2'h3 && !i_CFG_WR
         && (i_LINE_ASSERT & select_r) == 16'h0000)
        |=> o_PENDING == ($past(pending_r) & ~$past(i_MEM_WDATA)))
        else $error("write one to clear misbehaved");

    cfg_w1c_a: assert property (
        (i_CFG_WR && i_CFG_ADDR == `SIRQ_CFG_PEND_OFS && i_CFG_BE == 2'h3 && !i_MEM_WR
         && (i_LINE_ASSERT & select_r) == 16'h0000)
        |=> o_PENDING == ($past(pending_r) & ~$past(i_CFG_WDATA)))
        else $error("write one to clear through config alias misbehaved");

    byte_lane_a: assert property (
        (i_MEM_WR && i_MEM_ADDR == `SIRQ_MEM_PEND_OFS && !i_MEM_BE[1]
         && !(i_CFG_WR && i_CFG_ADDR == `SIRQ_CFG_PEND_OFS))
        |=> (o_PENDING & $past(pending_r) & 16'hff00) == ($past(pending_r) & 16'hff00))
        else $error("disabled byte lane cleared pending bits");

    zero_write_a: assert property (
        (i_MEM_WR && i_MEM_ADDR == `SIRQ_MEM_PEND_OFS
         && !(i_CFG_WR && i_CFG_ADDR == `SIRQ_CFG_PEND_OFS))
        |=> (o_PENDING & $past(pending_r) & ~$past(i_MEM_WDATA))
            == ($past(pending_r) & ~$past(i_MEM_WDATA)))
        else $error("written zero cleared a pending bit");

    pend_sticky_a: assert property (
        ##1 (($past(pending_r) & ~$past(clr_w)) & ~o_PENDING) == 16'h0000)
        else $error("pending bit dropped without a clear");

    set_wins_a: assert property (
        |(clr_w & set_w)
        |=> (o_PENDING & $past(clr_w) & $past(set_w)) == ($past(clr_w) & $past(set_w)))
        else $error("clear beat a same-cycle assertion");

    // overrides the default disable so the registers are watched while reset is held
    reset_value_a: assert property (
        disable iff (1'b0)
        (!I_RESET_N && !$past(I_RESET_N))
        |-> (select_r == `SIRQ_TRIG_RESET && pending_r == `SIRQ_PEND_RESET))
        else $error("registers not at reset value");

endmodule

/* verification/sirq_agent_model.sv */
// serial irq agent model driving per-line frame strobes
`timescale 1ns/1ps
module sirq_agent_model
    import sirq_pkg::*;
(
    input  wire logic i_mclk,
    output line_vec_t o_line_assert
);
    initial o_line_assert = 16'h0000;
    // a strobe lasts one frame slot, then the lines fall quiet again
    task automatic fire(input line_vec_t mask);
        @(posedge i_mclk);
        #1 o_line_assert = mask;
        @(posedge i_mclk);
        #1 o_line_assert = 16'h0000;
    endtask
endmodule

/* verification/serial_irq_trigger_status_tb.sv */
// self-checking bench for the serial irq trigger/status block
`timescale 1ns/1ps
`include "sirq_map.svh"
module serial_irq_trigger_status_tb
    import sirq_pkg::*;
;
    logic      clk, rst_n, mwr, mrd, cwr, crd;
    reg_addr_t ma, ca;
    byte_en_t  be;
    line_vec_t mw, cw, mq, cq, la, sel, pend, ev, s, l, d, p, q;
    int        num_errors, num_checks, cyc, seed;
    sirq_agent_model i_agent (.i_mclk(clk), .o_line_assert(la));
    serial_irq_trigger_status i_dut (.I_MCLK(clk), .I_RESET_N(rst_n), .i_LINE_ASSERT(la),
        .i_MEM_WR(mwr), .i_MEM_RD(mrd), .i_MEM_ADDR(ma), .i_MEM_BE(be), .i_MEM_WDATA(mw),
        .o_MEM_RDATA(mq), .i_CFG_WR(cwr), .i_CFG_RD(crd), .i_CFG_ADDR(ca), .i_CFG_BE(be),
        .i_CFG_WDATA(cw), .o_CFG_RDATA(cq), .o_LEVEL_SELECT(sel), .o_PENDING(pend),
        .o_EDGE_EVENT(ev));
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    task automatic close_out;
        if (num_errors == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            close_out;
        end
    end
    task automatic check(input string n, input line_vec_t e, input line_vec_t g);
        num_checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h got %h", n, e, g);
            num_errors++;
        end
    endtask
    // one strobe per access; read data is registered, so it is taken one edge later
    task automatic access(input bit c, input bit w, input reg_addr_t a, input line_vec_t v);
        @(posedge clk);
        #1;
        if (c) {cwr, crd, ca, cw} = {w, !w, a, v};
        else {mwr, mrd, ma, mw} = {w, !w, a, v};
        @(posedge clk);
        #1 {mwr, mrd, cwr, crd} = 4'h0;
        q = c ? cq : mq;
    endtask
    function automatic line_vec_t cleared(line_vec_t x, line_vec_t v, byte_en_t b);
        return x & ~(v & {{8{b[1]}}, {8{b[0]}}});
    endfunction
    initial begin
        {rst_n, mwr, mrd, cwr, crd, ma, ca, mw, cw} = '0;
        {num_errors, num_checks, cyc, p} = '0;
        be = 2'h3;
        seed = 32'he3fc171b;
        repeat (16) @(posedge clk);
        #1 rst_n = 1;
        access(0, 0, `SIRQ_MEM_TRIG_OFS, 0);
        check("select", `SIRQ_TRIG_RESET, q);
        access(1, 0, `SIRQ_CFG_PEND_OFS, 0);
        check("pending", `SIRQ_PEND_RESET, q);
        for (int k = 0; k < 8; k++) begin
            s = (k == 0) ? 16'hffff : (k == 1) ? 16'h0000 : 16'($random(seed));
            l = (k < 2) ? 16'hffff : 16'($random(seed));
            be = 2'h3;
            access(k[0], 1, k[0] ? `SIRQ_CFG_TRIG_OFS : `SIRQ_MEM_TRIG_OFS, s);
            check("level select", s, sel);
            access(!k[0], 0, k[0] ? `SIRQ_MEM_TRIG_OFS : `SIRQ_CFG_TRIG_OFS, 0);
            check("select alias", s, q);
            i_agent.fire(l);
            check("edge event", l & ~s, ev);
            p = p | (l & s);
            check("pending", p, pend);
            i_agent.fire(l);
            check("pending held", p, pend);
            d = 16'($random(seed));
            be = 2'($random(seed));
            access(k[1], 1, k[1] ? `SIRQ_CFG_PEND_OFS : `SIRQ_MEM_PEND_OFS, d);
            p = cleared(p, d, be);
            check("pending w1c", p, pend);
            access(!k[1], 0, k[1] ? `SIRQ_MEM_PEND_OFS : `SIRQ_CFG_PEND_OFS, 0);
            check("pending alias", p, q);
        end
        // both windows in one cycle, then a config write read back at once
        be = 2'h3;
        s = 16'($random(seed));
        @(posedge clk);
        #1 {mwr, ma, mw} = {1'b1, `SIRQ_MEM_TRIG_OFS, s};
        {cwr, ca, cw} = {1'b1, `SIRQ_CFG_TRIG_OFS, ~s};
        @(posedge clk);
        #1 {mwr, cw} = {1'b0, s ^ 16'h00ff};
        check("select mem wins", s, sel);
        @(posedge clk);
        #1 {cwr, mrd} = 2'h1;
        check("select cfg write", s ^ 16'h00ff, sel);
        @(posedge clk);
        #1 mrd = 0;
        check("select back to back", s ^ 16'h00ff, mq);
        // an assertion landing in the clearing cycle must survive
        fork
            i_agent.fire(16'hffff);
            access(1, 1, `SIRQ_CFG_PEND_OFS, 16'hffff);
        join
        check("pending set wins", s ^ 16'h00ff, pend);
        access(1, 1, `SIRQ_CFG_PEND_OFS, 16'hffff);
        check("pending cleared", 16'h0000, pend);
        access(0, 0, 8'h4e, 0);
        check("unmapped", 16'h0000, q);
        access(0, 1, `SIRQ_MEM_TRIG_OFS, 16'hffff);
        i_agent.fire(16'hffff);
        check("pending before reset", 16'hffff, pend);
        @(posedge clk);
        #1 rst_n = 0;
        #1 check("select", `SIRQ_TRIG_RESET, sel);
        check("pending", `SIRQ_PEND_RESET, pend);
        close_out;
    end
endmodule
